// *** design/adccr_pkg.sv ***
package adccr_pkg;

	// register port widths
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;

	// register offsets on the control port
	localparam logic [7:0] OFS_DSP_CONFIG_ZERO = 8'h6b;
	localparam logic [7:0] OFS_DSP_CONFIG_ONE  = 8'h6c;
	localparam logic [7:0] OFS_INPUT_ENABLES   = 8'h73;
	localparam logic [7:0] OFS_SLOT_ENABLES    = 8'h74;

	// reset values
	localparam logic [7:0] RST_DSP_CONFIG_ZERO = 8'h01;
	localparam logic [7:0] RST_DSP_CONFIG_ONE  = 8'h40;
	localparam logic [7:0] RST_INPUT_ENABLES   = 8'hc0;
	localparam logic [7:0] RST_SLOT_ENABLES    = 8'h00;

	// field positions, dsp config zero
	localparam int DECIM_LSB = 4;
	localparam int SUM_LSB   = 2;
	localparam int HPF_LSB   = 0;
	// field positions, dsp config one
	localparam int GANG_BIT  = 7;
	localparam int BIQ_LSB   = 5;
	localparam int SOFT_BIT  = 4;
	// enable registers: channel one at the top bit, low nibble reserved
	localparam int EN_TOP_BIT           = 7;
	localparam logic [7:0] EN_WRITE_MASK = 8'hf0;

	// volume codes
	localparam logic [7:0] VOL_MUTE  = 8'h00;
	localparam logic [7:0] VOL_UNITY = 8'hc9;

	// fixed high-pass cutoffs in millionths of the output rate
	localparam logic [13:0] HPF_CUSTOM_PPM = 14'h0000;
	localparam logic [13:0] HPF_FC1_PPM    = 14'h00fa;
	localparam logic [13:0] HPF_FC2_PPM    = 14'h07d0;
	localparam logic [13:0] HPF_FC3_PPM    = 14'h1f40;

	// decimation filter response
	typedef enum logic [1:0] {
		DECIM_LINEAR,
		DECIM_LOW_LAT,
		DECIM_ULTRA_LOW,
		DECIM_RSVD
	} adccr_decim_e;

	// channel summation mode
	typedef enum logic [1:0] {
		SUM_OFF,
		SUM_AVG_ONE_TWO,
		SUM_RSVD2,
		SUM_RSVD3
	} adccr_sum_e;

	// high-pass selection
	typedef enum logic [1:0] {
		HPF_CUSTOM_IIR,
		HPF_FIXED_FC1,
		HPF_FIXED_FC2,
		HPF_FIXED_FC3
	} adccr_hpf_e;

	// decoded configuration handed to the processing chain
	typedef struct packed {
		adccr_decim_e decimation_response_sel;
		adccr_sum_e   channel_summation_sel;
		adccr_hpf_e   highpass_select;
		logic         highpass_custom;
		logic [13:0]  highpass_cutoff_ppm;
		logic         volume_ganging;
		logic [1:0]   biquad_count;
		logic         soft_step_en;
	} adccr_cfg_s;

endpackage

// *** design/adccr_volume_sum.sv ***
`timescale 1ns/1ns
// per-channel volume selection with ganging, and two-channel averaging
module adccr_volume_sum #(
	parameter int SAMPLE_W = 24
) (
	input  wire logic                clk_i,
	input  wire logic                rst_b_i,
	input  wire logic                gang_i,
	input  wire logic                sum_avg_i,
	input  wire logic [3:0][7:0]     vol_i,
	input  wire logic [SAMPLE_W-1:0] samp_one_i,
	input  wire logic [SAMPLE_W-1:0] samp_two_i,
	output logic      [3:0][7:0]     vol_o,
	output logic      [3:0]          mute_o,
	output logic      [SAMPLE_W-1:0] samp_o
);

	// whole state of this stage
	typedef struct packed {
		logic [3:0][7:0]     vol;
		logic [3:0]          mute;
		logic [SAMPLE_W-1:0] samp;
	} adccr_vs_state_s;

	adccr_vs_state_s state_reg;  // registered state
	adccr_vs_state_s state_next; // next state
	logic [SAMPLE_W:0] sum_wide; // one extra bit so the sum never wraps

	// pick volumes, detect mute, average the first two channels
	always_comb
	begin
		state_next = state_reg;
		sum_wide   = {samp_one_i[SAMPLE_W-1], samp_one_i}
			+ {samp_two_i[SAMPLE_W-1], samp_two_i};
		for (int ch = 0; ch < 4; ch++)
		begin
			// ganged: all channels follow channel one [RL7] [RL6]
			state_next.vol[ch]  = gang_i ? vol_i[0] : vol_i[ch];
			// code zero mutes [RL16]
			state_next.mute[ch] = (state_next.vol[ch] == adccr_pkg::VOL_MUTE);
		end
		// average is the arithmetic half of the sum [RL2]
		state_next.samp = sum_avg_i ? sum_wide[SAMPLE_W:1] : samp_one_i;
	end

	// register the stage
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			state_reg <= '0;
		else
			state_reg <= state_next;
	end

	assign vol_o  = state_reg.vol;
	assign mute_o = state_reg.mute;
	assign samp_o = state_reg.samp;

	gang_volume_a: assert property ( // [RL7]
		@(posedge clk_i) disable iff (!rst_b_i)
		gang_i |=> (vol_o[3] == $past(vol_i[0]))
		&& (vol_o[1] == $past(vol_i[0])))
		else $error("ganged channel not using channel one volume");

	own_volume_a: assert property ( // [RL6]
		@(posedge clk_i) disable iff (!rst_b_i)
		!gang_i |=> (vol_o[2] == $past(vol_i[2])))
		else $error("unganged channel lost its own volume");

	sum_average_a: assert property ( // [RL2]
		@(posedge clk_i) disable iff (!rst_b_i)
		sum_avg_i |=> (samp_o == $past(sum_wide[SAMPLE_W:1])))
		else $error("summed output is not the average");

	mute_code_a: assert property ( // [RL16]
		@(posedge clk_i) disable iff (!rst_b_i)
		mute_o[0] |-> (vol_o[0] == 8'h00))
		else $error("mute flagged on a nonzero volume");

endmodule // adccr_volume_sum

// *** design/adccr_top.sv ***
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ns
// How it works
// (RL1) decimation code picks linear, low, ultra-low latency
// (RL2) summation code one averages channels one, two
// (RL3) high-pass code zero routes custom all-pass IIR
// (RL4) codes one to three pick fixed cutoffs
// (RL5) high-pass selection resets to code one
// (RL6) ganging clear: each channel own volume
// (RL7) ganging set: all channels use channel one
// (RL8) biquad count equals field, resets to two
// (RL9) soft-step bit clear ramps, set steps at once
// (RL10) top four bits enable inputs, reset one-one-zero-zero
// (RL11) disabled output slot is left undriven
// (RL12) top four bits enable slots, reset disabled
// (RL13) software writes reset values into reserved bits
// (RL14) software avoids reserved decimation and summation codes
// (RL15) power-up bit powers only enabled channels
// (RL16) volume zero mutes, code 201 is unity
module adccr_top #(
	parameter int SAMPLE_W = 24
) (
	input  wire logic                      CLK_SYS_I,
	input  wire logic                      RST_B_I,
	input  wire logic [7:0]                REG_ADDR_I,
	input  wire logic [7:0]                REG_WDATA_I,
	input  wire logic                      REG_WR_I,
	input  wire logic                      REG_RD_I,
	output logic      [7:0]                REG_RDATA_O,
	input  wire logic                      CH_POWER_UP_I,
	input  wire logic [3:0][7:0]           CH_VOLUME_I,
	input  wire logic [SAMPLE_W-1:0]       SAMPLE_ONE_I,
	input  wire logic [SAMPLE_W-1:0]       SAMPLE_TWO_I,
	input  wire logic                      SER_BIT_I,
	input  wire logic [1:0]                SER_SLOT_I,
	input  wire logic                      SER_ACTIVE_I,
	output adccr_pkg::adccr_cfg_s          CFG_O,
	output logic      [3:0]                CH_INPUT_EN_O,
	output logic      [3:0]                CH_POWERED_O,
	output logic      [3:0][7:0]           CH_VOLUME_O,
	output logic      [3:0]                CH_MUTED_O,
	output logic      [SAMPLE_W-1:0]       SAMPLE_O,
	output logic                           SDOUT_O,
	output logic                           SDOUT_OE_O
);

	// whole state of the register bank
	typedef struct packed {
		logic [7:0]            cfg_zero;  // dsp config zero
		logic [7:0]            cfg_one;   // dsp config one
		logic [7:0]            in_en;     // input channel enables
		logic [7:0]            slot_en;   // output slot enables
		logic [7:0]            rdata;     // read answer
		adccr_pkg::adccr_cfg_s cfg;       // decoded configuration
		logic [3:0]            in_ch;     // input enables by channel
		logic [3:0]            powered;   // channels powered up
		logic                  sd;        // serial data out
		logic                  sd_oe;     // serial data drive enable
	} adccr_state_s;

	// enable bits by channel: index zero is channel one at the top bit
	function automatic logic [3:0] chan_bits(input logic [7:0] r);
		logic [3:0] b;
		b = '0;
		for (int ch = 0; ch < 4; ch++)
			b[ch] = r[adccr_pkg::EN_TOP_BIT - ch];
		return b;
	endfunction

	// decode both config registers into the chain settings
	function automatic adccr_pkg::adccr_cfg_s decode_cfg(
		input logic [7:0] c0,
		input logic [7:0] c1
	);
		adccr_pkg::adccr_cfg_s d;
		d.decimation_response_sel =
			adccr_pkg::adccr_decim_e'(c0[adccr_pkg::DECIM_LSB +: 2]); // [RL1]
		d.channel_summation_sel =
			adccr_pkg::adccr_sum_e'(c0[adccr_pkg::SUM_LSB +: 2]);
		d.highpass_select =
			adccr_pkg::adccr_hpf_e'(c0[adccr_pkg::HPF_LSB +: 2]);
		d.highpass_custom = 1'h0;
		// choose filter from the high-pass code
		case (d.highpass_select)
			adccr_pkg::HPF_CUSTOM_IIR:
			begin
				// programmable section, all-pass by default [RL3]
				d.highpass_custom     = 1'h1;
				d.highpass_cutoff_ppm = adccr_pkg::HPF_CUSTOM_PPM;
			end
			adccr_pkg::HPF_FIXED_FC1:
				d.highpass_cutoff_ppm = adccr_pkg::HPF_FC1_PPM; // [RL4]
			adccr_pkg::HPF_FIXED_FC2:
				d.highpass_cutoff_ppm = adccr_pkg::HPF_FC2_PPM; // [RL4]
			adccr_pkg::HPF_FIXED_FC3:
				d.highpass_cutoff_ppm = adccr_pkg::HPF_FC3_PPM; // [RL4]
			default:
				d.highpass_cutoff_ppm = adccr_pkg::HPF_CUSTOM_PPM;
		endcase
		d.volume_ganging = c1[adccr_pkg::GANG_BIT];          // [RL6] [RL7]
		d.biquad_count   = c1[adccr_pkg::BIQ_LSB +: 2];      // [RL8]
		d.soft_step_en   = !c1[adccr_pkg::SOFT_BIT];         // [RL9]
		return d;
	endfunction

	// state after reset
	localparam adccr_state_s STATE_RST = '{
		cfg_zero: adccr_pkg::RST_DSP_CONFIG_ZERO, // [RL1] [RL2] [RL5]
		cfg_one:  adccr_pkg::RST_DSP_CONFIG_ONE,  // [RL6] [RL8] [RL9]
		in_en:    adccr_pkg::RST_INPUT_ENABLES,   // [RL10]
		slot_en:  adccr_pkg::RST_SLOT_ENABLES,    // [RL12]
		rdata:    8'h00,
		cfg:      decode_cfg(adccr_pkg::RST_DSP_CONFIG_ZERO,
			adccr_pkg::RST_DSP_CONFIG_ONE),
		in_ch:    chan_bits(adccr_pkg::RST_INPUT_ENABLES),
		powered:  4'h0,
		sd:       1'h0,
		sd_oe:    1'h0
	};

	adccr_state_s state_reg;   // registered state
	adccr_state_s state_next;  // next state
	logic [3:0]   slot_ch;     // slot enables by channel, current

	assign slot_ch = chan_bits(state_reg.slot_en);

	// register writes, read answer, power and serial drive
	always_comb
	begin
		state_next       = state_reg;
		state_next.rdata = 8'h00;
		// writes: config registers keep all bits
		if (REG_WR_I)
		begin
			case (REG_ADDR_I)
				adccr_pkg::OFS_DSP_CONFIG_ZERO:
					state_next.cfg_zero = REG_WDATA_I;
				adccr_pkg::OFS_DSP_CONFIG_ONE:
					state_next.cfg_one = REG_WDATA_I;
				// low nibble is read-only zero [RL10] [RL13]
				adccr_pkg::OFS_INPUT_ENABLES:
					state_next.in_en = REG_WDATA_I & adccr_pkg::EN_WRITE_MASK;
				adccr_pkg::OFS_SLOT_ENABLES:
					state_next.slot_en = REG_WDATA_I & adccr_pkg::EN_WRITE_MASK;
				// unmapped writes are dropped
				default:
					state_next.rdata = 8'h00;
			endcase
		end
		// reads answer in the next cycle, unmapped reads give zero
		if (REG_RD_I)
		begin
			case (REG_ADDR_I)
				adccr_pkg::OFS_DSP_CONFIG_ZERO:
					state_next.rdata = state_reg.cfg_zero;
				adccr_pkg::OFS_DSP_CONFIG_ONE:
					state_next.rdata = state_reg.cfg_one;
				adccr_pkg::OFS_INPUT_ENABLES:
					state_next.rdata = state_reg.in_en;
				adccr_pkg::OFS_SLOT_ENABLES:
					state_next.rdata = state_reg.slot_en;
				default:
					state_next.rdata = 8'h00;
			endcase
		end
		// decoded settings track the registers in the same cycle
		state_next.cfg   = decode_cfg(state_next.cfg_zero, state_next.cfg_one);
		state_next.in_ch = chan_bits(state_next.in_en);          // [RL10]
		// power only enabled channels, all off when cleared [RL15]
		state_next.powered = CH_POWER_UP_I ? state_reg.in_ch : 4'h0;
		// drive the slot only when its enable is set [RL11] [RL12]
		state_next.sd_oe = SER_ACTIVE_I && slot_ch[SER_SLOT_I];
		state_next.sd    = state_next.sd_oe ? SER_BIT_I : 1'h0;
	end

	// register the bank
	always_ff @(posedge CLK_SYS_I or negedge RST_B_I)
	begin
		if (!RST_B_I)
			state_reg <= STATE_RST;
		else
			state_reg <= state_next;
	end

	// volume ganging and two-channel summation stage
	adccr_volume_sum #(
		.SAMPLE_W (SAMPLE_W)
	) u_volume_sum (
		.clk_i      (CLK_SYS_I),
		.rst_b_i    (RST_B_I),
		.gang_i     (state_reg.cfg.volume_ganging),
		.sum_avg_i  (state_reg.cfg.channel_summation_sel
			== adccr_pkg::SUM_AVG_ONE_TWO),
		.vol_i      (CH_VOLUME_I),
		.samp_one_i (SAMPLE_ONE_I),
		.samp_two_i (SAMPLE_TWO_I),
		.vol_o      (CH_VOLUME_O),
		.mute_o     (CH_MUTED_O),
		.samp_o     (SAMPLE_O)
	);

	// outputs straight from the state register
	assign REG_RDATA_O   = state_reg.rdata;
	assign CFG_O         = state_reg.cfg;
	assign CH_INPUT_EN_O = state_reg.in_ch;
	assign CH_POWERED_O  = state_reg.powered;
	assign SDOUT_O       = state_reg.sd;
	assign SDOUT_OE_O    = state_reg.sd_oe;

	reset_values_a: assert property (@(posedge CLK_SYS_I) // [RL5]
		$rose(RST_B_I) |-> (CFG_O.highpass_select == adccr_pkg::HPF_FIXED_FC1)
		&& (CFG_O.biquad_count == 2'h2) && (CH_INPUT_EN_O == 4'h3)
		&& (state_reg.slot_en == 8'h00) && CFG_O.soft_step_en)
		else $error("bank did not come out of reset at defaults");

	decim_write_a: assert property ( // [RL1]
		@(posedge CLK_SYS_I) disable iff (!RST_B_I)
		REG_WR_I && (REG_ADDR_I == adccr_pkg::OFS_DSP_CONFIG_ZERO)
		&& (REG_WDATA_I[5:4] == 2'h2)
		|=> (CFG_O.decimation_response_sel == adccr_pkg::DECIM_ULTRA_LOW))
		else $error("ultra-low latency code not applied");

	// every response code written shows up decoded one cycle later
	decim_code_a: assert property ( // [RL1]
		@(posedge CLK_SYS_I) disable iff (!RST_B_I)
		REG_WR_I && (REG_ADDR_I == adccr_pkg::OFS_DSP_CONFIG_ZERO)
		|=> (CFG_O.decimation_response_sel == $past(REG_WDATA_I[5:4])))
		else $error("decimation response code not taken");

	// only code one turns averaging on
	sum_select_a: assert property ( // [RL2]
		@(posedge CLK_SYS_I) disable iff (!RST_B_I)
		REG_WR_I && (REG_ADDR_I == adccr_pkg::OFS_DSP_CONFIG_ZERO)
		|=> ((CFG_O.channel_summation_sel == adccr_pkg::SUM_AVG_ONE_TWO)
		== ($past(REG_WDATA_I[3:2]) == 2'h1)))
		else $error("summation code not taken");

	hpf_cutoff_a: assert property ( // [RL4]
		@(posedge CLK_SYS_I) disable iff (!RST_B_I)
		(CFG_O.highpass_select == adccr_pkg::HPF_FIXED_FC3)
		|-> (CFG_O.highpass_cutoff_ppm == 14'h1f40) && !CFG_O.highpass_custom)
		else $error("third fixed cutoff wrong");

	// lowest fixed cutoff, the one active after reset
	hpf_fixed_a: assert property ( // [RL4]
		@(posedge CLK_SYS_I) disable iff (!RST_B_I)
		(CFG_O.highpass_select == adccr_pkg::HPF_FIXED_FC1)
		|-> (CFG_O.highpass_cutoff_ppm == 14'h00fa) && !CFG_O.highpass_custom)
		else $error("first fixed cutoff wrong");

	hpf_middle_a: assert property ( // [RL4]
		@(posedge CLK_SYS_I) disable iff (!RST_B_I)
		(CFG_O.highpass_select == adccr_pkg::HPF_FIXED_FC2)
		|-> (CFG_O.highpass_cutoff_ppm == 14'h07d0) && !CFG_O.highpass_custom)
		else $error("second fixed cutoff wrong");

	hpf_custom_a: assert property ( // [RL3]
		@(posedge CLK_SYS_I) disable iff (!RST_B_I)
		REG_WR_I && (REG_ADDR_I == adccr_pkg::OFS_DSP_CONFIG_ZERO)
		&& (REG_WDATA_I[1:0] == 2'h0) |=> CFG_O.highpass_custom)
		else $error("custom IIR not routed on code zero");

	soft_step_a: assert property ( // [RL9]
		@(posedge CLK_SYS_I) disable iff (!RST_B_I)
		REG_WR_I && (REG_ADDR_I == adccr_pkg::OFS_DSP_CONFIG_ONE)
		|=> (CFG_O.soft_step_en == !$past(REG_WDATA_I[4]))
		&& (CFG_O.biquad_count == $past(REG_WDATA_I[6:5])))
		else $error("soft-step or biquad count not taken");

	gang_write_a: assert property ( // [RL7]
		@(posedge CLK_SYS_I) disable iff (!RST_B_I)
		REG_WR_I && (REG_ADDR_I == adccr_pkg::OFS_DSP_CONFIG_ONE)
		|=> (CFG_O.volume_ganging == $past(REG_WDATA_I[7])))
		else $error("volume ganging bit not taken");

	in_enable_a: assert property ( // [RL10]
		@(posedge CLK_SYS_I) disable iff (!RST_B_I)
		REG_WR_I && (REG_ADDR_I == adccr_pkg::OFS_INPUT_ENABLES)
		|=> (CH_INPUT_EN_O[0] == $past(REG_WDATA_I[7]))
		&& (CH_INPUT_EN_O[3] == $past(REG_WDATA_I[4]))
		&& (state_reg.in_en[3:0] == 4'h0))
		else $error("input enable mapping wrong");

	slot_write_a: assert property ( // [RL12]
		@(posedge CLK_SYS_I) disable iff (!RST_B_I)
		REG_WR_I && (REG_ADDR_I == adccr_pkg::OFS_SLOT_ENABLES)
		|=> (state_reg.slot_en == {$past(REG_WDATA_I[7:4]), 4'h0}))
		else $error("slot enable write not taken");

	power_gate_a: assert property ( // [RL15]
		@(posedge CLK_SYS_I) disable iff (!RST_B_I)
		CH_POWER_UP_I |=> ((CH_POWERED_O & ~$past(CH_INPUT_EN_O)) == 4'h0))
		else $error("disabled channel was powered");

	power_down_a: assert property ( // [RL15]
		@(posedge CLK_SYS_I) disable iff (!RST_B_I)
		!CH_POWER_UP_I |=> (CH_POWERED_O == 4'h0))
		else $error("channel still powered after power-down");

	power_match_a: assert property ( // [RL15]
		@(posedge CLK_SYS_I) disable iff (!RST_B_I)
		CH_POWER_UP_I |=> (CH_POWERED_O == $past(CH_INPUT_EN_O)))
		else $error("enabled channel was not powered");

	slot_tristate_a: assert property ( // [RL11]
		@(posedge CLK_SYS_I) disable iff (!RST_B_I)
		SER_ACTIVE_I && !state_reg.slot_en[7 - SER_SLOT_I] |=> !SDOUT_OE_O)
		else $error("disabled slot was driven");

	slot_drive_a: assert property ( // [RL12]
		@(posedge CLK_SYS_I) disable iff (!RST_B_I)
		SER_ACTIVE_I && state_reg.slot_en[7 - SER_SLOT_I]
		|=> SDOUT_OE_O && (SDOUT_O == $past(SER_BIT_I)))
		else $error("enabled slot not driven");

	read_back_a: assert property ( // [RL13]
		@(posedge CLK_SYS_I) disable iff (!RST_B_I)
		REG_RD_I && (REG_ADDR_I == adccr_pkg::OFS_SLOT_ENABLES)
		|=> (REG_RDATA_O[3:0] == 4'h0))
		else $error("reserved slot bits read nonzero");

endmodule // adccr_top

// *** tb/test_adccr_top.sv ***
`timescale 1ns/1ns
// register bank bench: bus tasks, then test sequences with expected values
module test_adccr_top;
	// design inputs
	logic                  CLK_SYS_I;
	logic                  RST_B_I;
	logic [7:0]            REG_ADDR_I;
	logic [7:0]            REG_WDATA_I;
	logic                  REG_WR_I;
	logic                  REG_RD_I;
	logic                  CH_POWER_UP_I;
	logic [3:0][7:0]       CH_VOLUME_I;
	logic [23:0]           SAMPLE_ONE_I;
	logic [23:0]           SAMPLE_TWO_I;
	logic                  SER_BIT_I;
	logic [1:0]            SER_SLOT_I;
	logic                  SER_ACTIVE_I;
	// design outputs
	logic [7:0]            REG_RDATA_O;
	adccr_pkg::adccr_cfg_s CFG_O;
	logic [3:0]            CH_INPUT_EN_O;
	logic [3:0]            CH_POWERED_O;
	logic [3:0][7:0]       CH_VOLUME_O;
	logic [3:0]            CH_MUTED_O;
	logic [23:0]           SAMPLE_O;
	logic                  SDOUT_O;
	logic                  SDOUT_OE_O;
	// bookkeeping
	int                    miscompares;
	int                    n_checks;
	int                    cyc;
	logic [7:0]            rdat;
	logic                  en;
	// cutoff in millionths of the rate per high-pass code
	logic [13:0]           ppm_tab [4] = '{14'h0000, 14'h00fa, 14'h07d0,
		14'h1f40};

	// device under test
	adccr_top #(.SAMPLE_W(24)) dut_u (
		.CLK_SYS_I(CLK_SYS_I), .RST_B_I(RST_B_I),
		.REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I),
		.REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I),
		.REG_RDATA_O(REG_RDATA_O), .CH_POWER_UP_I(CH_POWER_UP_I),
		.CH_VOLUME_I(CH_VOLUME_I), .SAMPLE_ONE_I(SAMPLE_ONE_I),
		.SAMPLE_TWO_I(SAMPLE_TWO_I), .SER_BIT_I(SER_BIT_I),
		.SER_SLOT_I(SER_SLOT_I), .SER_ACTIVE_I(SER_ACTIVE_I),
		.CFG_O(CFG_O), .CH_INPUT_EN_O(CH_INPUT_EN_O),
		.CH_POWERED_O(CH_POWERED_O), .CH_VOLUME_O(CH_VOLUME_O),
		.CH_MUTED_O(CH_MUTED_O), .SAMPLE_O(SAMPLE_O),
		.SDOUT_O(SDOUT_O), .SDOUT_OE_O(SDOUT_OE_O)
	);

	// 250 MHz clock
	initial
	begin
		CLK_SYS_I = 1'h0;
		forever #2 CLK_SYS_I = ~CLK_SYS_I;
	end

	// hang guard, well above the roughly 135 cycles the tests need
	always @(posedge CLK_SYS_I)
	begin
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			miscompares = miscompares + 1;
			finish_test();
		end
	end

	// compare one value and count it
	task automatic chk(input string what, input logic [23:0] seen,
		input logic [23:0] exp);
		n_checks = n_checks + 1;
		if (seen !== exp)
		begin
			miscompares = miscompares + 1;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// one-cycle write strobe
	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge CLK_SYS_I);
		REG_ADDR_I  <= a;
		REG_WDATA_I <= d;
		REG_WR_I    <= 1'h1;
		@(posedge CLK_SYS_I);
		REG_WR_I    <= 1'h0;
	endtask

	// one-cycle read strobe, data taken in the following cycle
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge CLK_SYS_I);
		REG_ADDR_I <= a;
		REG_RD_I   <= 1'h1;
		@(posedge CLK_SYS_I);
		REG_RD_I   <= 1'h0;
		#1;
		rdat = REG_RDATA_O;
		chk("read data", 24'(rdat), 24'(exp));
	endtask

	// let registered outputs follow held inputs
	task automatic settle();
		repeat (3) @(posedge CLK_SYS_I);
		#1;
	endtask

	// counts, verdict and end of run
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// main sequence
	initial
	begin
		miscompares = 0;
		n_checks = 0;
		cyc = 0;
		RST_B_I = 1'h0;
		REG_ADDR_I = 8'h00;
		REG_WDATA_I = 8'h00;
		REG_WR_I = 1'h0;
		REG_RD_I = 1'h0;
		CH_POWER_UP_I = 1'h0;
		CH_VOLUME_I = {8'hff, 8'h00, 8'h10, 8'hc9};
		SAMPLE_ONE_I = 24'hfffffa;
		SAMPLE_TWO_I = 24'h000003;
		SER_BIT_I = 1'h0;
		SER_SLOT_I = 2'h0;
		SER_ACTIVE_I = 1'h0;
		repeat (12) @(posedge CLK_SYS_I);
		RST_B_I <= 1'h1;
		// reset values through the port and the decoded outputs
		rd_chk(8'h6b, 8'h01);
		rd_chk(8'h6c, 8'h40);
		rd_chk(8'h73, 8'hc0);
		rd_chk(8'h74, 8'h00);
		chk("decim", 24'(CFG_O.decimation_response_sel), 24'h0);
		chk("hpf", 24'(CFG_O.highpass_select), 24'h1);
		chk("biquads", 24'(CFG_O.biquad_count), 24'h2);
		chk("soft", 24'(CFG_O.soft_step_en), 24'h1);
		chk("gang", 24'(CFG_O.volume_ganging), 24'h0);
		chk("in en", 24'(CH_INPUT_EN_O), 24'h3);
		$display("test reset values done");
		// every non-reserved filter and summation code, every high-pass code
		for (int i = 0; i < 4; i++)
		begin
			reg_wr(8'h6b, {2'h0, 2'(i % 3), 2'(i % 2), 2'(i)});
			settle();
			chk("decim", 24'(CFG_O.decimation_response_sel), 24'(i % 3));
			chk("sum", 24'(CFG_O.channel_summation_sel), 24'(i % 2));
			chk("hpf", 24'(CFG_O.highpass_select), 24'(i));
			chk("custom", 24'(CFG_O.highpass_custom), 24'(i == 0));
			chk("cutoff", 24'(CFG_O.highpass_cutoff_ppm), 24'(ppm_tab[i]));
			// average of -6 and 3 rounds down to -2
			chk("sample", SAMPLE_O, (i % 2) ? 24'hfffffe : 24'hfffffa);
			rd_chk(8'h6b, {2'h0, 2'(i % 3), 2'(i % 2), 2'(i)});
		end
		$display("test filter codes done");
		// ganging, biquad count and soft-step, channel one muted in the last two passes
		for (int j = 0; j < 4; j++)
		begin
			@(posedge CLK_SYS_I);
			CH_VOLUME_I[0] <= j[1] ? 8'h00 : 8'hc9;
			reg_wr(8'h6c, {j[0], 2'(j), j[1], 4'h0});
			settle();
			chk("biquads", 24'(CFG_O.biquad_count), 24'(j));
			chk("soft", 24'(CFG_O.soft_step_en), 24'(!j[1]));
			chk("gang", 24'(CFG_O.volume_ganging), 24'(j[0]));
			for (int k = 0; k < 4; k++)
			begin
				chk("volume", 24'(CH_VOLUME_O[k]),
					24'(j[0] ? CH_VOLUME_I[0] : CH_VOLUME_I[k]));
				chk("muted", 24'(CH_MUTED_O[k]),
					24'((j[0] ? CH_VOLUME_I[0] : CH_VOLUME_I[k]) == 8'h00));
			end
		end
		$display("test volume and biquads done");
		// input enables and the power-up gate
		@(posedge CLK_SYS_I);
		CH_POWER_UP_I <= 1'h1;
		reg_wr(8'h73, 8'h5f);
		settle();
		rd_chk(8'h73, 8'h50);
		chk("in en", 24'(CH_INPUT_EN_O), 24'ha);
		chk("powered", 24'(CH_POWERED_O), 24'ha);
		reg_wr(8'h73, 8'hac);
		settle();
		chk("powered", 24'(CH_POWERED_O), 24'h5);
		@(posedge CLK_SYS_I);
		CH_POWER_UP_I <= 1'h0;
		settle();
		chk("powered", 24'(CH_POWERED_O), 24'h0);
		$display("test input enables done");
		// output slots: channels one and three enabled
		reg_wr(8'h74, 8'haf);
		rd_chk(8'h74, 8'ha0);
		for (int k = 0; k < 8; k++)
		begin
			@(posedge CLK_SYS_I);
			SER_ACTIVE_I <= 1'h1;
			SER_SLOT_I <= 2'(k / 2);
			SER_BIT_I <= k[0];
			settle();
			en = (k / 2 == 0) || (k / 2 == 2);
			chk("drive en", 24'(SDOUT_OE_O), 24'(en));
			chk("data", 24'(SDOUT_O), 24'(en & k[0]));
		end
		@(posedge CLK_SYS_I);
		SER_ACTIVE_I <= 1'h0;
		settle();
		chk("drive en", 24'(SDOUT_OE_O), 24'h0);
		// unmapped place ignores writes and reads zero
		reg_wr(8'h70, 8'hff);
		rd_chk(8'h70, 8'h00);
		rd_chk(8'h74, 8'ha0);
		$display("test output slots done");
		finish_test();
	end
endmodule // test_adccr_top
